/* File: verilog/tls_pkg.sv */
// Package for the temperature limit, status and alarm block.
// Assumes a bus engine that turns serial transfers into single-cycle register strobes.
package tls_pkg;

  // ==========================================================================
  // Register addresses (read and write sides differ for some registers)
  // ==========================================================================
  localparam logic [7:0] ADR_LOCAL_RES      = 8'h00;
  localparam logic [7:0] ADR_REMOTE_RES_HI  = 8'h01;
  localparam logic [7:0] ADR_ALARM_FLAGS    = 8'h02;
  localparam logic [7:0] ADR_CONFIG_RD      = 8'h03;
  localparam logic [7:0] ADR_CONFIG_WR      = 8'h09;
  localparam logic [7:0] ADR_LOCAL_HIGH_RD  = 8'h05;
  localparam logic [7:0] ADR_LOCAL_LOW_RD   = 8'h06;
  localparam logic [7:0] ADR_REM_HIGH_HI_RD = 8'h07;
  localparam logic [7:0] ADR_REM_LOW_HI_RD  = 8'h08;
  localparam logic [7:0] ADR_LOCAL_HIGH_WR  = 8'h0B;
  localparam logic [7:0] ADR_LOCAL_LOW_WR   = 8'h0C;
  localparam logic [7:0] ADR_REM_HIGH_HI_WR = 8'h0D;
  localparam logic [7:0] ADR_REM_LOW_HI_WR  = 8'h0E;
  localparam logic [7:0] ADR_SINGLE_CONV    = 8'h0F;
  localparam logic [7:0] ADR_REMOTE_RES_LO  = 8'h10;
  localparam logic [7:0] ADR_OFFSET_INT     = 8'h11;
  localparam logic [7:0] ADR_OFFSET_FRAC    = 8'h12;
  localparam logic [7:0] ADR_REM_HIGH_LO    = 8'h13;
  localparam logic [7:0] ADR_REM_LOW_LO     = 8'h14;
  localparam logic [7:0] ADR_REMOTE_CRIT    = 8'h19;
  localparam logic [7:0] ADR_LOCAL_CRIT     = 8'h20;
  localparam logic [7:0] ADR_CRIT_HYST      = 8'h21;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int CFG_IRQ_MASK   = 7;
  localparam int CFG_STANDBY    = 6;
  localparam int CFG_PIN_SEL    = 5;
  localparam int CFG_RANGE      = 2;
  localparam logic [7:0] CFG_WR_MASK = 8'hE4;
  localparam int ST_BUSY        = 7;
  localparam int ST_LOCAL_OVER  = 6;
  localparam int ST_LOCAL_UNDER = 5;
  localparam int ST_REM_OVER    = 4;
  localparam int ST_REM_UNDER   = 3;
  localparam int ST_OPEN        = 2;
  localparam int ST_REM_CRIT    = 1;
  localparam int ST_LOCAL_CRIT  = 0;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0] RST_CONFIG    = 8'h00;
  localparam logic [7:0] RST_HIGH_LIM  = 8'h55;
  localparam logic [7:0] RST_LOW_LIM   = 8'h00;
  localparam logic [7:0] RST_CRIT_LIM  = 8'h55;
  localparam logic [7:0] RST_CRIT_HYST = 8'h0A;
  localparam logic [7:0] RST_ZERO      = 8'h00;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic       wr;     // Write strobe, one cycle
    logic       rd;     // Read strobe, one cycle
    logic [7:0] addr;   // Register address
    logic [7:0] wdata;  // Write data
  } tls_reg_req_t;

  typedef struct packed {
    logic [7:0] local_temp;   // Local result, whole degrees
    logic [9:0] remote_raw;   // Remote result, 8.2 fixed point
    logic       open_diode;   // Remote sensor open
  } tls_meas_t;

endpackage

/* File: verilog/tls_core.sv */
// Limit compare, status flags and alarm outputs of a two-channel temperature monitor.
// Assumes a bus engine giving one-cycle register strobes and a front end with a done pulse.
`timescale 1ns/100ps

module tls_core (
  input  wire logic                  clk,            // 200 MHz clock
  input  wire logic                  rst,            // Synchronous reset, active high
  input  wire tls_pkg::tls_reg_req_t reg_req,        // Register strobe, address, data
  output logic [7:0]                 reg_rdata,      // Read data, one cycle after rd
  input  wire logic                  ara_read,       // Host read our address in alert service
  input  wire logic                  rate_tick,      // Conversion-rate timer pulse
  output logic                       conv_start,     // Start one conversion, pulse
  input  wire logic                  meas_valid,     // Conversion done, pulse
  input  wire tls_pkg::tls_meas_t    meas,           // Results with meas_valid
  output logic                       overtemp_out_n, // Critical alarm, active low
  output logic                       alert_out_n     // Interrupt or second alarm, active low
);

  // ==========================================================================
  // Registers
  // ==========================================================================
  typedef enum logic [0:0] {S_IDLE, S_CONV} tls_state_t;
  tls_state_t state;
  logic [7:0] config_reg, local_high, local_low, rem_high_hi, rem_low_hi;
  logic [7:0] rem_high_lo, rem_low_lo, remote_crit, local_crit_lim, crit_hyst;
  logic [7:0] offset_int, offset_frac;
  logic [7:0] local_res;
  logic [9:0] remote_res;
  logic       open_res, eval, single_pend, irq_latch;
  logic [6:2] flags;
  logic       local_crit_st, remote_crit_st, local_hi2_st, remote_hi2_st;

  // Hysteresis comparator: set above limit, release at limit minus hysteresis
  function automatic logic hyst_next(input logic cur, input logic [9:0] t,
                                     input logic [9:0] lim, input logic [9:0] h);
    logic [10:0] sum;
    sum = {1'b0, t} + {1'b0, h};
    if (t > lim) hyst_next = 1'b1;
    else if (sum <= {1'b0, lim}) hyst_next = 1'b0;
    else hyst_next = cur;
  endfunction

  // ==========================================================================
  // Decode
  // ==========================================================================
  wire wr = reg_req.wr;
  wire rd = reg_req.rd;
  wire pin_sel   = config_reg[tls_pkg::CFG_PIN_SEL];
  wire irq_mask  = config_reg[tls_pkg::CFG_IRQ_MASK];
  wire standby   = config_reg[tls_pkg::CFG_STANDBY];
  wire busy      = (state == S_CONV);
  wire stat_read = rd && (reg_req.addr == tls_pkg::ADR_ALARM_FLAGS);
  wire one_shot  = wr && (reg_req.addr == tls_pkg::ADR_SINGLE_CONV);
  wire start_go  = (state == S_IDLE) && (single_pend || (rate_tick && !standby));

  // Limits and results in 8.2 form; whole-degree bytes get two zero fraction bits appended
  wire [9:0] local_q     = {local_res, 2'b00};
  wire [9:0] local_hi_q  = {local_high, 2'b00};
  wire [9:0] rem_hi_q    = {rem_high_hi, rem_high_lo[7:6]};
  wire [9:0] rem_lo_q    = {rem_low_hi, rem_low_lo[7:6]};
  wire [9:0] hyst_q      = {crit_hyst, 2'b00};

  wire c_local_over  = local_res > local_high;
  wire c_local_under = local_res <= local_low;
  wire c_rem_over    = remote_res > rem_hi_q;
  wire c_rem_under   = remote_res <= rem_lo_q;
  wire [6:2] cond    = {c_local_over, c_local_under, c_rem_over, c_rem_under, open_res};

  // Offset: sign and integer in one byte, two fraction bits left-justified
  wire signed [11:0] offset_s = {{2{offset_int[7]}}, offset_int, offset_frac[7:6]};
  wire signed [11:0] rem_sum  = $signed({2'b00, meas.remote_raw}) + offset_s;
  // Saturate instead of wrapping so a large negative offset cannot read as hot
  wire [9:0] rem_corr = rem_sum[11] ? 10'h000 : (rem_sum[10] ? 10'h3FF : rem_sum[9:0]);

  wire [7:0] status = {busy, flags, remote_crit_st, local_crit_st};
  wire alert_clear  = ara_read && (flags == 5'h00) && (cond == 5'h00);

  // ==========================================================================
  // Conversion sequencing
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= S_IDLE;
      single_pend <= 1'b0;
      eval <= 1'b0;
    end else begin
      eval <= meas_valid && busy;
      if (start_go) begin
        state <= S_CONV;
      end else if (busy && meas_valid) begin
        state <= S_IDLE;
      end
      // A standby write landing on the start cycle queues one more conversion
      if (one_shot && standby) begin
        single_pend <= 1'b1;
      end else if (start_go) begin
        single_pend <= 1'b0;
      end
    end
  end
  assign conv_start = start_go;

  always_ff @(posedge clk) begin
    if (rst) begin
      local_res <= tls_pkg::RST_ZERO;
      remote_res <= 10'h000;
      open_res <= 1'b0;
    end else if (busy && meas_valid) begin
      local_res <= meas.local_temp;
      remote_res <= rem_corr;
      open_res <= meas.open_diode;
    end
  end

  // ==========================================================================
  // Host registers
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (rst) begin
      config_reg <= tls_pkg::RST_CONFIG;
      local_high <= tls_pkg::RST_HIGH_LIM;
      local_low <= tls_pkg::RST_LOW_LIM;
      rem_high_hi <= tls_pkg::RST_HIGH_LIM;
      rem_low_hi <= tls_pkg::RST_LOW_LIM;
      rem_high_lo <= tls_pkg::RST_ZERO;
      rem_low_lo <= tls_pkg::RST_ZERO;
      remote_crit <= tls_pkg::RST_CRIT_LIM;
      local_crit_lim <= tls_pkg::RST_CRIT_LIM;
      crit_hyst <= tls_pkg::RST_CRIT_HYST;
      offset_int <= tls_pkg::RST_ZERO;
      offset_frac <= tls_pkg::RST_ZERO;
    end else if (wr) begin
      case (reg_req.addr)
        tls_pkg::ADR_CONFIG_WR:      config_reg <= reg_req.wdata & tls_pkg::CFG_WR_MASK;
        tls_pkg::ADR_LOCAL_HIGH_WR:  local_high <= reg_req.wdata;
        tls_pkg::ADR_LOCAL_LOW_WR:   local_low <= reg_req.wdata;
        tls_pkg::ADR_REM_HIGH_HI_WR: rem_high_hi <= reg_req.wdata;
        tls_pkg::ADR_REM_LOW_HI_WR:  rem_low_hi <= reg_req.wdata;
        tls_pkg::ADR_REM_HIGH_LO:    rem_high_lo <= {reg_req.wdata[7:6], 6'h00};
        tls_pkg::ADR_REM_LOW_LO:     rem_low_lo <= {reg_req.wdata[7:6], 6'h00};
        tls_pkg::ADR_REMOTE_CRIT:    remote_crit <= reg_req.wdata;
        tls_pkg::ADR_LOCAL_CRIT:     local_crit_lim <= reg_req.wdata;
        tls_pkg::ADR_CRIT_HYST:      crit_hyst <= reg_req.wdata;
        tls_pkg::ADR_OFFSET_INT:     offset_int <= reg_req.wdata;
        tls_pkg::ADR_OFFSET_FRAC:    offset_frac <= {reg_req.wdata[7:6], 6'h00};
        default: ;                                   // 0x0F data dropped
      endcase
    end
  end

  // Read mux; status is read-only, unmapped addresses return zero
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (rd) begin
      case (reg_req.addr)
        tls_pkg::ADR_LOCAL_RES:      reg_rdata <= local_res;
        tls_pkg::ADR_REMOTE_RES_HI:  reg_rdata <= remote_res[9:2];
        tls_pkg::ADR_REMOTE_RES_LO:  reg_rdata <= {remote_res[1:0], 6'h00};
        tls_pkg::ADR_ALARM_FLAGS:    reg_rdata <= status;
        tls_pkg::ADR_CONFIG_RD:      reg_rdata <= config_reg;
        tls_pkg::ADR_LOCAL_HIGH_RD:  reg_rdata <= local_high;
        tls_pkg::ADR_LOCAL_LOW_RD:   reg_rdata <= local_low;
        tls_pkg::ADR_REM_HIGH_HI_RD: reg_rdata <= rem_high_hi;
        tls_pkg::ADR_REM_LOW_HI_RD:  reg_rdata <= rem_low_hi;
        tls_pkg::ADR_REM_HIGH_LO:    reg_rdata <= rem_high_lo;
        tls_pkg::ADR_REM_LOW_LO:     reg_rdata <= rem_low_lo;
        tls_pkg::ADR_REMOTE_CRIT:    reg_rdata <= remote_crit;
        tls_pkg::ADR_LOCAL_CRIT:     reg_rdata <= local_crit_lim;
        tls_pkg::ADR_CRIT_HYST:      reg_rdata <= crit_hyst;
        tls_pkg::ADR_OFFSET_INT:     reg_rdata <= offset_int;
        tls_pkg::ADR_OFFSET_FRAC:    reg_rdata <= offset_frac;
        default:                     reg_rdata <= 8'h00;
      endcase
    end
  end

  // ==========================================================================
  // Flags, hysteresis and latch
  // ==========================================================================
  // Hysteresis states follow stored values every cycle, so limit writes in
  // standby still move the outputs.
  always_ff @(posedge clk) begin
    if (rst) begin
      local_crit_st <= 1'b0;
      remote_crit_st <= 1'b0;
      local_hi2_st <= 1'b0;
      remote_hi2_st <= 1'b0;
    end else begin
      local_crit_st <= hyst_next(local_crit_st, local_q, {local_crit_lim, 2'b00}, hyst_q);
      remote_crit_st <= hyst_next(remote_crit_st, {remote_res[9:2], 2'b00},
                                  {remote_crit, 2'b00}, hyst_q);
      local_hi2_st <= hyst_next(local_hi2_st, local_q, local_hi_q, hyst_q);
      remote_hi2_st <= hyst_next(remote_hi2_st, remote_res, rem_hi_q, hyst_q);
    end
  end

  // A set on evaluation wins over a clear from a status read in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      flags <= 5'h00;
    end else begin
      if (pin_sel) begin
        if (eval) begin
          flags[6:3] <= {c_local_over, 1'b0, c_rem_over, 1'b0};
        end
        if (eval && cond[2]) begin
          flags[2] <= 1'b1;
        end else if (stat_read && !cond[2]) begin
          flags[2] <= 1'b0;
        end
      end else begin
        for (int i = 2; i <= 6; i++) begin
          if (eval && cond[i]) begin
            flags[i] <= 1'b1;
          end else if (stat_read && !cond[i]) begin
            flags[i] <= 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_latch <= 1'b0;
    end else if (!pin_sel && (flags != 5'h00)) begin
      irq_latch <= 1'b1;
    end else if (alert_clear || pin_sel) begin
      irq_latch <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      overtemp_out_n <= 1'b1;
      alert_out_n <= 1'b1;
    end else begin
      overtemp_out_n <= !(local_crit_st || remote_crit_st);
      alert_out_n <= pin_sel ? !(local_hi2_st || remote_hi2_st)
                             : !(irq_latch && !irq_mask);
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  sequence s_single_write;
    one_shot && standby && !busy && !single_pend;
  endsequence
  sequence s_started;
    ##[1:2] conv_start;
  endsequence

  property p_single_conv;
    @(posedge clk) disable iff (rst) s_single_write |-> s_started;
  endproperty
  a_single_conv: assert property (p_single_conv) else $error("single conversion not started");

  property p_high_flag;
    @(posedge clk) disable iff (rst) eval && !pin_sel && c_local_over |=> flags[6];
  endproperty
  a_high_flag: assert property (p_high_flag) else $error("local over flag missing");

  property p_low_flag;
    @(posedge clk) disable iff (rst) eval && !pin_sel && c_rem_under |=> flags[3];
  endproperty
  a_low_flag: assert property (p_low_flag) else $error("remote under flag missing");

  property p_crit_out;
    @(posedge clk) disable iff (rst) local_crit_st || remote_crit_st |=> !overtemp_out_n;
  endproperty
  a_crit_out: assert property (p_crit_out) else $error("overtemp output not low");

  property p_hyst_hold;
    @(posedge clk) disable iff (rst)
      local_crit_st && ({1'b0, local_q} + {1'b0, hyst_q} > {1'b0, local_crit_lim, 2'b00})
      |=> local_crit_st;
  endproperty
  a_hyst_hold: assert property (p_hyst_hold) else $error("critical released early");

  property p_busy_bit;
    @(posedge clk) disable iff (rst) stat_read |=> reg_rdata[7] == $past(busy);
  endproperty
  a_busy_bit: assert property (p_busy_bit) else $error("busy bit wrong");

  property p_flag_held;
    @(posedge clk) disable iff (rst) stat_read && !pin_sel && flags[5] && c_local_under |=> flags[5];
  endproperty
  a_flag_held: assert property (p_flag_held) else $error("flag cleared while active");

  property p_latch_survives;
    @(posedge clk) disable iff (rst) irq_latch && stat_read && !ara_read && !pin_sel |=> irq_latch;
  endproperty
  a_latch_survives: assert property (p_latch_survives) else $error("latch lost on read");

  property p_second_alarm;
    @(posedge clk) disable iff (rst) pin_sel && remote_hi2_st ##1 pin_sel |-> !alert_out_n;
  endproperty
  a_second_alarm: assert property (p_second_alarm) else $error("second alarm not low");

  property p_mask;
    @(posedge clk) disable iff (rst) !pin_sel && irq_mask ##1 !pin_sel && irq_mask |-> alert_out_n;
  endproperty
  a_mask: assert property (p_mask) else $error("masked interrupt drove low");

endmodule

/* File: testbench/tls_front_model.sv */
// Behavioural measurement front end: one result pulse per conversion start.
// Assumes the bench sets the value to report before the conversion ends.
`timescale 1ns/100ps
// ============================================================================
// Front end
// ============================================================================
module tls_front_model #(parameter int LAT = 6) (
  input  wire logic               clk,        // Clock
  input  wire logic               rst,        // Reset, active high
  input  wire logic               conv_start, // Conversion begins
  input  wire tls_pkg::tls_meas_t value,      // Result to report
  output logic                    meas_valid, // Result pulse
  output tls_pkg::tls_meas_t      meas        // Result, scrambled outside the pulse
);
  logic [3:0] cnt;
  always_ff @(posedge clk) begin
    if (rst) cnt <= 4'h0;
    else if (conv_start) cnt <= 4'(LAT);
    else if (cnt != 4'h0) cnt <= cnt - 4'h1;
  end
  assign meas_valid = (cnt == 4'h1);
  // Inverted outside the pulse so a stray sample cannot pass unnoticed
  assign meas = meas_valid ? value : ~value;
endmodule

/* File: testbench/testbench.sv */
// Self-checking bench for the limit, status and alarm block.
// Assumes the front-end model and a single 200 MHz clock.
`timescale 1ns/100ps
module testbench;
  logic               clk, rst, ara_read, rate_tick, conv_start, meas_valid, ot_n, al_n, lc, rc, op;
  tls_pkg::tls_reg_req_t req;
  tls_pkg::tls_meas_t value, meas;
  logic [7:0]         d, lt, rt, ofs, ex, rdata;
  logic [1:0]         fr;
  logic [9:0]         eff;
  int                 failures, n_checks, seed, i, k;
  logic [7:0] wa [11] = '{8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h13, 8'h14, 8'h19, 8'h20, 8'h21, 8'h11, 8'h12};
  logic [7:0] ra [11] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h13, 8'h14, 8'h19, 8'h20, 8'h21, 8'h11, 8'h12};
  logic [7:0] rv [11] = '{8'h55, 8'h00, 8'h55, 8'h00, 8'h00, 8'h00, 8'h55, 8'h55, 8'h0A, 8'h00, 8'h00};
  logic [7:0] mk [11] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hC0, 8'hC0, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hC0};
  // ==========================================================================
  // Clock, design and far side
  // ==========================================================================
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  tls_core dut_u (.clk(clk), .rst(rst), .reg_req(req), .reg_rdata(rdata), .ara_read(ara_read),
    .rate_tick(rate_tick), .conv_start(conv_start), .meas_valid(meas_valid), .meas(meas),
    .overtemp_out_n(ot_n), .alert_out_n(al_n));
  tls_front_model fe_u (.clk(clk), .rst(rst), .conv_start(conv_start), .value(value),
    .meas_valid(meas_valid), .meas(meas));
  // ==========================================================================
  // Tasks and expectations
  // ==========================================================================
  task automatic end_sim();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk) req <= '{1'b1, 1'b0, a, v};
    @(posedge clk) req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk) req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk) req <= '0;
    #1 v = rdata;
  endtask
  // Bounded wait for the result pulse, then let flags and outputs settle
  task automatic wait_conv();
    k = 0;
    while (k < 50 && meas_valid !== 1'b1) begin
      #5;
      k++;
    end
    repeat (5) @(posedge clk);
    #1;
  endtask
  task automatic convert();
    wr(8'h0F, 8'($random(seed)));
    rd(8'h02, d);
    chk(8'(d[7]), 8'h01);
    wait_conv();
  endtask
  task automatic tick(input logic [7:0] busy);
    @(posedge clk) rate_tick <= 1'b1;
    @(posedge clk) rate_tick <= 1'b0;
    rd(8'h02, d);
    chk(8'(d[7]), busy);
    wait_conv();
  endtask
  function automatic logic [7:0] pick(input int r);
    logic [7:0] c [6] = '{8'h00, 8'h01, 8'h4B, 8'h4C, 8'h55, 8'h56};
    return r[3] ? c[r[2:0] % 6] : 8'(r) & 8'h7F;
  endfunction
  // Saturating sum of raw result and signed offset
  function automatic logic [9:0] add_ofs(input logic [9:0] raw, input logic [7:0] oi,
                                         input logic [1:0] of);
    logic signed [11:0] s;
    s = $signed({2'b00, raw}) + $signed({{2{oi[7]}}, oi, of});
    if (s < 0) return 10'h000;
    if (s > 12'sd1023) return 10'h3FF;
    return s[9:0];
  endfunction
  initial begin
    #100000;
    failures++;
    end_sim();
  end
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  initial begin
    seed = 20;
    failures = 0;
    n_checks = 0;
    lc = 1'b0;
    rc = 1'b0;
    rst = 1'b1;
    req = '0;
    ara_read = 1'b0;
    rate_tick = 1'b0;
    value = '{8'h20, 10'h080, 1'b0};
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 11; i++) begin
      rd(ra[i], d);
      chk(d & mk[i], rv[i]);
      ex = 8'($random(seed));
      wr(wa[i], ex);
      rd(ra[i], d);
      chk(d & mk[i], ex & mk[i]);
      wr(wa[i], rv[i]);
    end
    rd(8'h30, d);
    chk(d, 8'h00);
    tick(8'h01);
    wr(8'h09, 8'h40);
    tick(8'h00);
    for (i = 0; i < 30; i++) begin
      lt = pick($random(seed));
      rt = pick($random(seed));
      ofs = 8'($random(seed) % 8);
      fr = 2'($random(seed));
      op = ($random(seed) & 3) == 0;
      wr(8'h11, ofs);
      wr(8'h12, {fr, 6'($random(seed))});
      value = '{lt, {rt, 2'b00}, op};
      eff = add_ofs({rt, 2'b00}, ofs, fr);
      convert();
      rd(8'h00, d);
      chk(d, lt);
      rd(8'h01, d);
      chk(d, eff[9:2]);
      rd(8'h10, d);
      chk(d, {eff[1:0], 6'h00});
      if (lt > 8'h55) lc = 1'b1;
      else if (lt <= 8'h4B) lc = 1'b0;
      if (eff[9:2] > 8'h55) rc = 1'b1;
      else if (eff[9:2] <= 8'h4B) rc = 1'b0;
      ex = {1'b0, lt > 8'h55, lt == 8'h00, eff > 10'h154, eff == 10'h000, op, rc, lc};
      rd(8'h02, d);
      chk(d & ex, ex);
      rd(8'h02, d);
      chk(d, ex);
      if (ex[6:2] != 5'h00) chk(8'(al_n), 8'h00);
      chk(8'(ot_n), 8'(!(lc | rc)));
      @(posedge clk) ara_read <= 1'b1;
      @(posedge clk) ara_read <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk(8'(al_n), 8'(ex[6:2] == 5'h00));
    end
    rd(8'h0F, d);
    chk(d, 8'h00);
    rd(8'h03, d);
    chk(d, 8'h40);
    wr(8'h09, 8'hC0);
    value = '{8'h60, 10'h080, 1'b0};
    convert();
    chk({ot_n, al_n}, 8'h01);
    wr(8'h09, 8'h60);
    convert();
    chk(8'(al_n), 8'h00);
    value = '{8'h30, 10'h200, 1'b0};
    convert();
    chk({ot_n, al_n}, 8'h00);
    value = '{8'h20, 10'h080, 1'b0};
    convert();
    chk({ot_n, al_n}, 8'h03);
    rd(8'h02, d);
    chk(d & 8'hFB, 8'h00);
    rd(8'h02, d);
    chk(d, 8'h00);
    end_sim();
  end
endmodule
